//--- hw/epl_loader.sv
// Per-port configuration loader of a three-port switch with APB access.
// Assumes the image word port and APB run on pclk; the word source
// answers a held read request with a one-cycle acknowledge.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/100ps

module epl_loader #(
    parameter int NPORTS = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic ee_rd_req,
    output logic [7:0] ee_rd_addr,
    input wire logic ee_rd_ack,
    input wire logic ee_rd_ok,
    input wire logic [15:0] ee_rd_data,
    output logic load_done,
    output logic [7:0] pm_data,
    output logic [NPORTS-1:0] slot_clk_conn,
    output logic [NPORTS-1:0] dsi_required,
    output logic [NPORTS-1:0] low_priority_vc_count,
    output logic [3*NPORTS-1:0] logical_port_num,
    output logic [7*NPORTS-1:0] tc_vc0_map,
    output logic [NPORTS-1:0] slot_impl
);
    epl_pkg::epl_state_e state_q;
    localparam int NUM_W = epl_pkg::NUM_WORDS;
    logic [1:0] idx_q;
    logic [NUM_W-1:0] present_q;
    logic [7:0] pm_q;
    logic [15:0] wd_q [NPORTS];
    logic [13:0] cfg_sel_q;
    logic [31:0] prdata_q;
    logic cfg_ok_q;
    logic [31:0] rd_mux;
    logic [31:0] cfg_dw;
    logic take;
    logic wr_fire;
    logic reload;
    logic sel_cfg;
    logic mapped;
    logic [1:0] sel_port;

    // Image word address for each load step
    function automatic logic [7:0] word_addr(input logic [1:0] i);
        case (i)
            2'h0: word_addr = epl_pkg::WORD_PM_DATA;
            2'h1: word_addr = epl_pkg::WORD_PORT0;
            2'h2: word_addr = epl_pkg::WORD_PORT1;
            default: word_addr = epl_pkg::WORD_PORT2;
        endcase
    endfunction

    // Handshake and bus decode
    assign take = (state_q == epl_pkg::EPL_READ) && ee_rd_ack;
    assign wr_fire = psel && penable && pready && pwrite;
    assign reload = wr_fire && paddr == epl_pkg::REG_CTRL &&
                    pwdata[epl_pkg::CTRL_RELOAD_BIT];
    assign sel_cfg = paddr == epl_pkg::REG_CFG_DATA;
    assign mapped = paddr == epl_pkg::REG_CTRL ||
                    paddr == epl_pkg::REG_STATUS ||
                    paddr == epl_pkg::REG_CFG_SEL || sel_cfg;
    assign ee_rd_req = state_q == epl_pkg::EPL_READ;
    assign ee_rd_addr = word_addr(idx_q);
    assign load_done = state_q == epl_pkg::EPL_DONE;

    // Load sequencer: starts at reset release, reruns on a reload in EPL_DONE
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= epl_pkg::EPL_IDLE;
            idx_q <= 2'h0;
        end else begin
            case (state_q)
                epl_pkg::EPL_IDLE: begin
                    state_q <= epl_pkg::EPL_READ;
                    idx_q <= 2'h0;
                end
                epl_pkg::EPL_READ: begin
                    if (ee_rd_ack) begin
                        idx_q <= idx_q + 2'h1;
                        if (idx_q == 2'(NUM_W - 1)) begin
                            state_q <= epl_pkg::EPL_DONE;
                        end
                    end
                end
                epl_pkg::EPL_DONE: begin
                    if (reload) begin
                        state_q <= epl_pkg::EPL_READ;
                        idx_q <= 2'h0;
                    end
                end
                default: state_q <= epl_pkg::EPL_IDLE;
            endcase
        end
    end

    // Record which words were present in the last load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            present_q <= '0;
        end else if (take) begin
            present_q[idx_q] <= ee_rd_ok;
        end
    end

    // Power management data, port 2 only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_q <= epl_pkg::DEF_PM_DATA;
        end else if (take && ee_rd_ok && idx_q == 2'h0) begin
            pm_q <= ee_rd_data[epl_pkg::W_PMDATA_MSB:
                               epl_pkg::W_PMDATA_LSB];
        end
    end
    assign pm_data = pm_q;

    // One image word per port, same layout for every port
    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                wd_q[p] <= epl_pkg::DEF_PORT_WORD;
            end else if (take && ee_rd_ok && idx_q == 2'(p + 1)) begin
                wd_q[p] <= ee_rd_data;
            end
        end
        assign slot_clk_conn[p] = wd_q[p][epl_pkg::W_SLOT_CLK];
        assign dsi_required[p] = wd_q[p][epl_pkg::W_DSI];
        assign low_priority_vc_count[p] =
            wd_q[p][epl_pkg::W_LOW_VC];
        assign logical_port_num[3*p +: 3] =
            wd_q[p][epl_pkg::W_PNUM_MSB:epl_pkg::W_PNUM_LSB];
        assign tc_vc0_map[7*p +: 7] =
            wd_q[p][epl_pkg::W_TCMAP_MSB:epl_pkg::W_TCMAP_LSB];
        // Port 0 has no slot bit
        assign slot_impl[p] = (p != 0) &&
            wd_q[p][epl_pkg::W_SLOT_IMPL];
    end

    // Configuration selector register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_sel_q <= epl_pkg::CFG_SEL_RESET;
        end else if (wr_fire && paddr == epl_pkg::REG_CFG_SEL) begin
            cfg_sel_q <= pwdata[13:0];
        end
    end
    assign sel_port = cfg_sel_q[epl_pkg::SEL_PORT_LSB +: 2];

    // Configuration dword view of the selected port
    always_comb begin
        cfg_dw = 32'h0000_0000;
        if (32'(sel_port) < NPORTS) begin
            case ({cfg_sel_q[11:2], 2'b00})
                epl_pkg::CFG_DSI_OFF:
                    cfg_dw[epl_pkg::CFG_DSI_BIT] = dsi_required[sel_port];
                epl_pkg::CFG_PMDATA_OFF:
                    if (sel_port == 2'h2) begin
                        cfg_dw[epl_pkg::CFG_PMDATA_LSB +: 8] = pm_q;
                    end
                epl_pkg::CFG_SLOT_IMPL_OFF:
                    cfg_dw[epl_pkg::CFG_SLOT_IMPL_BIT] = slot_impl[sel_port];
                epl_pkg::CFG_PNUM_OFF:
                    cfg_dw[epl_pkg::CFG_PNUM_LSB +: 3] =
                        logical_port_num[3*sel_port +: 3];
                epl_pkg::CFG_SLOT_CLK_OFF:
                    cfg_dw[epl_pkg::CFG_SLOT_CLK_BIT] =
                        slot_clk_conn[sel_port];
                epl_pkg::CFG_LOW_VC_OFF:
                    cfg_dw[epl_pkg::CFG_LOW_VC_BIT] =
                        low_priority_vc_count[sel_port];
                epl_pkg::CFG_TCMAP_OFF:
                    cfg_dw[epl_pkg::CFG_TCMAP_LSB +: 7] =
                        tc_vc0_map[7*sel_port +: 7];
                default: cfg_dw = 32'h0000_0000;
            endcase
        end
    end

    // Read data select
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            epl_pkg::REG_STATUS: begin
                rd_mux[epl_pkg::ST_DONE_BIT] = load_done;
                rd_mux[epl_pkg::ST_BUSY_BIT] = ee_rd_req;
                rd_mux[epl_pkg::ST_PRESENT_LSB +: NUM_W] = present_q;
            end
            epl_pkg::REG_CFG_SEL: rd_mux[13:0] = cfg_sel_q;
            epl_pkg::REG_CFG_DATA: rd_mux = cfg_dw;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is captured each selected cycle, one behind the address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            cfg_ok_q <= 1'b0;
        end else begin
            if (psel) begin
                prdata_q <= rd_mux;
            end
            cfg_ok_q <= load_done;
        end
    end
    assign prdata = prdata_q;

    // Configuration reads stall until one cycle after the load has finished
    assign pready = !sel_cfg || (load_done && cfg_ok_q);
    assign pslverr = psel && penable && !mapped;

    // Checks
    sequence s_take(logic [7:0] a);
        take && ee_rd_ok && ee_rd_addr == a;
    endsequence

    sequence s_stall;
        psel && penable && sel_cfg && !load_done;
    endsequence

    pm_data_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_take(epl_pkg::WORD_PM_DATA) |=>
        pm_data == $past(ee_rd_data[15:8]))
        else $error("pm data not loaded from word 55h");
    slot_clk_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_take(epl_pkg::WORD_PORT0) |=>
        slot_clk_conn[0] == $past(ee_rd_data[1]))
        else $error("slot clock bit not loaded");
    dsi_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_take(epl_pkg::WORD_PORT1) |=>
        dsi_required[1] == $past(ee_rd_data[2]))
        else $error("device init bit not loaded");
    low_vc_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_take(epl_pkg::WORD_PORT2) |=>
        low_priority_vc_count[2] == $past(ee_rd_data[3]))
        else $error("low priority vc bit not loaded");
    port_num_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_take(epl_pkg::WORD_PORT0) |=>
        logical_port_num[2:0] == $past(ee_rd_data[6:4]))
        else $error("logical port number not loaded");
    tc_map_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_take(epl_pkg::WORD_PORT1) |=>
        tc_vc0_map[13:7] == $past(ee_rd_data[15:9]))
        else $error("tc map not loaded");
    slot_impl_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_take(epl_pkg::WORD_PORT2) |=>
        slot_impl[2] == $past(ee_rd_data[0]) && !slot_impl[0])
        else $error("slot implemented bit wrong");
    word_order_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        take && ee_rd_addr == epl_pkg::WORD_PM_DATA ##1 ee_rd_req |->
        ee_rd_addr == epl_pkg::WORD_PORT0)
        else $error("port 0 word not read after pm word");
    cfg_stall_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_stall |-> !pready)
        else $error("config read answered before load");
    absent_keep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        take && !ee_rd_ok |=> $stable(pm_q) && $stable(tc_vc0_map)
        && $stable(logical_port_num))
        else $error("absent word changed a field");
endmodule // epl_loader

//--- hw/epl_pkg.sv
// Constants of the per-port configuration loader: word addresses,
// field positions, default values and the register map.
// Assumes one core clock and an APB register port.
package epl_pkg;
    // Image word addresses, in load order
    localparam logic [7:0] WORD_PM_DATA = 8'h55;
    localparam logic [7:0] WORD_PORT0 = 8'h60;
    localparam logic [7:0] WORD_PORT1 = 8'h62;
    localparam logic [7:0] WORD_PORT2 = 8'h64;
    localparam int NUM_WORDS = 4;

    // Field positions inside an image word
    localparam int W_SLOT_IMPL = 0;
    localparam int W_SLOT_CLK = 1;
    localparam int W_DSI = 2;
    localparam int W_LOW_VC = 3;
    localparam int W_PNUM_LSB = 4;
    localparam int W_PNUM_MSB = 6;
    localparam int W_TCMAP_LSB = 9;
    localparam int W_TCMAP_MSB = 15;
    localparam int W_PMDATA_LSB = 8;
    localparam int W_PMDATA_MSB = 15;

    // Configuration space dword offsets and field positions
    localparam logic [11:0] CFG_DSI_OFF = 12'h040;
    localparam int CFG_DSI_BIT = 21;
    localparam logic [11:0] CFG_PMDATA_OFF = 12'h044;
    localparam int CFG_PMDATA_LSB = 24;
    localparam logic [11:0] CFG_SLOT_IMPL_OFF = 12'h0C0;
    localparam int CFG_SLOT_IMPL_BIT = 24;
    localparam logic [11:0] CFG_PNUM_OFF = 12'h0CC;
    localparam int CFG_PNUM_LSB = 24;
    localparam logic [11:0] CFG_SLOT_CLK_OFF = 12'h0D0;
    localparam int CFG_SLOT_CLK_BIT = 28;
    localparam logic [11:0] CFG_LOW_VC_OFF = 12'h144;
    localparam int CFG_LOW_VC_BIT = 4;
    localparam logic [11:0] CFG_TCMAP_OFF = 12'h154;
    localparam int CFG_TCMAP_LSB = 1;

    // Reset values, kept until a present word is loaded
    localparam logic [15:0] DEF_PORT_WORD = 16'h0000;
    localparam logic [7:0] DEF_PM_DATA = 8'h00;

    // APB register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CFG_SEL = 8'h08;
    localparam logic [7:0] REG_CFG_DATA = 8'h0C;
    localparam int CTRL_RELOAD_BIT = 0;
    localparam int ST_DONE_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_PRESENT_LSB = 4;
    localparam int SEL_PORT_LSB = 12;
    localparam logic [13:0] CFG_SEL_RESET = 14'h0000;

    // Load sequencer states
    typedef enum logic [2:0] {
        EPL_IDLE = 3'b001,
        EPL_READ = 3'b010,
        EPL_DONE = 3'b100
    } epl_state_e;
endpackage

//--- verification/epl_ee_model.sv
// Behavioural image word source for the configuration loader.
// Assumes pclk domain; answers a held read after lat idle cycles.
`timescale 1ns/100ps
module epl_ee_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ee_rd_req,
    input wire logic [7:0] ee_rd_addr,
    input wire logic [63:0] image,
    input wire logic [3:0] present,
    input wire logic [3:0] lat,
    output logic ee_rd_ack,
    output logic ee_rd_ok,
    output logic [15:0] ee_rd_data
);
    logic [2:0] idx;
    logic [3:0] wait_q;

    // Word slot of the requested address, 4 when none
    always_comb begin
        case (ee_rd_addr)
            8'h55: idx = 3'h0;
            8'h60: idx = 3'h1;
            8'h62: idx = 3'h2;
            8'h64: idx = 3'h3;
            default: idx = 3'h4;
        endcase
    end

    // One-cycle answer; data scrambles when not answering
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ee_rd_ack <= 1'h0;
            ee_rd_ok <= 1'h0;
            ee_rd_data <= 16'h0000;
            wait_q <= 4'h0;
        end else if (ee_rd_ack) begin
            ee_rd_ack <= 1'h0;
            ee_rd_ok <= !ee_rd_ok;
            ee_rd_data <= ~ee_rd_data;
            wait_q <= 4'h0;
        end else if (ee_rd_req && wait_q >= lat) begin
            ee_rd_ack <= 1'h1;
            ee_rd_ok <= idx < 3'h4 && present[idx[1:0]];
            ee_rd_data <= idx < 3'h4 && present[idx[1:0]] ?
                image[idx[1:0]*16 +: 16] : ~ee_rd_data;
        end else begin
            wait_q <= ee_rd_req ? wait_q + 4'h1 : 4'h0;
            ee_rd_data <= ~ee_rd_data;
        end
    end
endmodule // epl_ee_model

//--- verification/tb.sv
// Self-checking bench of the configuration loader with an APB master.
// Assumes epl_pkg and the word source model are compiled first.
`timescale 1ns/100ps
module tb;
    typedef struct packed {
        logic [63:0] w;
        logic [3:0] m, l;
        logic [7:0] pm;
        logic [2:0] ck, ds, lp, im;
        logic [8:0] pn;
        logic [20:0] tc;
    } epl_row_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, ee_rd_addr, pm_data;
    logic [31:0] pwdata, prdata, rd;
    logic ee_rd_req, ee_rd_ack, ee_rd_ok, load_done;
    logic [15:0] ee_rd_data;
    logic [2:0] slot_clk_conn, dsi_required, low_priority_vc_count, slot_impl;
    logic [8:0] logical_port_num;
    logic [20:0] tc_vc0_map;
    logic [63:0] image;
    logic [3:0] present, lat;
    int errors, num_checks, cycles, aidx, waits;
    epl_row_s rows [3];
    logic [7:0] addrs [4];

    epl_loader u_epl_loader (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr),
        .ee_rd_ack(ee_rd_ack), .ee_rd_ok(ee_rd_ok), .ee_rd_data(ee_rd_data),
        .load_done(load_done), .pm_data(pm_data),
        .slot_clk_conn(slot_clk_conn), .dsi_required(dsi_required),
        .low_priority_vc_count(low_priority_vc_count),
        .logical_port_num(logical_port_num), .tc_vc0_map(tc_vc0_map),
        .slot_impl(slot_impl));
    epl_ee_model u_epl_ee_model (.pclk(pclk), .presetn(presetn),
        .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr), .image(image),
        .present(present), .lat(lat), .ee_rd_ack(ee_rd_ack),
        .ee_rd_ok(ee_rd_ok), .ee_rd_data(ee_rd_data));

    task automatic chk(input string what, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; answer taken at the edge where pready is high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        waits = 0;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            waits++;
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic cfg(input logic [13:0] sel, input logic [31:0] exp,
                       input string what);
        apb(1'h1, epl_pkg::REG_CFG_SEL, {18'h0, sel});
        apb(1'h0, epl_pkg::REG_CFG_DATA, 32'h0);
        chk(what, exp, rd);
    endtask

    task automatic wait_done;
        int n;
        n = 0;
        @(posedge pclk);
        while (load_done !== 1'h1 && n < 300) begin
            n++;
            @(posedge pclk);
        end
        chk("load_done", 32'h1, {31'h0, load_done});
    endtask

    task automatic print_verdict;
        $display("Checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Clock at 25 MHz
    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end

    // Hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict;
        end
    end

    // Word addresses taken in load order
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            aidx = 0;
        else if (ee_rd_req === 1'h1 && ee_rd_ack === 1'h1) begin
            chk("ee_rd_addr", {24'h0, addrs[aidx]}, {24'h0, ee_rd_addr});
            aidx = (aidx + 1) % 4;
        end
    end

    // Rows, then reset and bus corner cases
    initial begin
        addrs = '{8'h55, 8'h60, 8'h62, 8'h64};
        rows[0] = '{64'hAA25_0000_FE7F_5A00, 4'hF, 4'h0, 8'h5A, 3'h1, 3'h5,
            3'h1, 3'h4, 9'h087, 21'h15407F};
        rows[1] = '{64'h0000_5A3B_0001_00FF, 4'hF, 4'h3, 8'h00, 3'h2, 3'h0,
            3'h2, 3'h2, 9'h018, 21'h001680};
        rows[2] = rows[1];
        rows[2].w = 64'hFFFF_FFFF_FFFF_FFFF;
        rows[2].m = 4'h0;
        rows[2].l = 4'h1;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {image, present, lat} = {rows[0].w, rows[0].m, rows[0].l};
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        for (int r = 0; r < 3; r++) begin
            if (r > 0) begin
                {image, present, lat} <= {rows[r].w, rows[r].m, rows[r].l};
                apb(1'h1, epl_pkg::REG_CTRL, 32'h1);
            end
            wait_done;
            chk("pm_data", 32'(rows[r].pm), 32'(pm_data));
            chk("slot_clk", 32'(rows[r].ck), 32'(slot_clk_conn));
            chk("dsi", 32'(rows[r].ds), 32'(dsi_required));
            chk("low_vc", 32'(rows[r].lp),
                32'(low_priority_vc_count));
            chk("port_num", 32'(rows[r].pn), 32'(logical_port_num));
            chk("tc_map", 32'(rows[r].tc), 32'(tc_vc0_map));
            chk("slot_impl", 32'(rows[r].im), 32'(slot_impl));
            apb(1'h0, epl_pkg::REG_STATUS, 32'h0);
            chk("status", {24'h0, rows[r].m, 4'h1}, rd);
            cfg(14'h2044, {rows[r].pm, 24'h0}, "cfg 44h");
            cfg(14'h0044, 32'h0, "cfg 44h p0");
            cfg(14'h10D0, {3'h0, rows[r].ck[1], 28'h0}, "cfg D0h");
            cfg(14'h0040, {10'h0, rows[r].ds[0], 21'h0}, "cfg 40h");
            cfg(14'h0144, {27'h0, rows[r].lp[0], 4'h0}, "cfg 144h");
            cfg(14'h10CC, {5'h0, rows[r].pn[5:3], 24'h0}, "cfg CCh");
            cfg(14'h0154, {24'h0, rows[r].tc[6:0], 1'h0}, "cfg 154h");
            cfg(14'h20C0, {7'h0, rows[r].im[2], 24'h0}, "cfg C0h");
            cfg(14'h00C0, 32'h0, "cfg C0h p0");
            cfg(14'h30CC, 32'h0, "cfg port 3");
            $display("Test row %0d done", r);
        end
        // Reset after word 55h of a slow reload, then a stalled read
        {image, present, lat} <= {rows[0].w, rows[0].m, 4'h8};
        apb(1'h1, epl_pkg::REG_CTRL, 32'h1);
        repeat (12) @(posedge pclk);
        chk("pm before reset", 32'h5A, 32'(pm_data));
        chk("busy before reset", 32'h1, 32'(ee_rd_req));
        presetn <= 1'h0;
        @(posedge pclk);
        chk("reset pm_data", 32'h0, 32'(pm_data));
        chk("reset req", 32'h0, 32'(ee_rd_req));
        chk("reset done", 32'h0, 32'(load_done));
        chk("reset prdata", 32'h0, prdata);
        presetn <= 1'h1;
        apb(1'h0, epl_pkg::REG_CFG_DATA, 32'h0);
        chk("stalled", 32'h1, 32'(waits > 0));
        chk("done at answer", 32'h1, 32'(load_done));
        chk("pm reloaded", 32'h5A, 32'(pm_data));
        chk("cfg after reset", 32'h0, rd);
        apb(1'h0, epl_pkg::REG_CFG_SEL, 32'h0);
        chk("cfg_sel reset", 32'h0, rd);
        apb(1'h0, 8'h10, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        $display("Test corner cases done");
        print_verdict;
    end
endmodule // tb
